//--- common/tcsac_pkg.sv
// Package: constants and carrier types for the Type-C source attach control
package tcsac_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;   // Core clock rate in MHz
  localparam int DEGR_MS          = 150;   // Flag assert settle time, ms
  localparam int DEGF_MS          = 12;    // Flag release settle time, ms
  localparam int DEGR_CYC         = DEGR_MS * 1000 * CLK_MHZ;
  localparam int DEGF_CYC         = DEGF_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Electrical figures, carried as reference values
  // ----------------------------------------------------------------------
  localparam int ILIM_MA          = 3400;  // Bus-power limit, mA typ
  localparam int HEAVY_MA         = 1950;  // Heavy-load threshold, mA typ
  localparam int TSD_C            = 135;   // Thermal turn-off, degC min
  localparam int TSD_HYST_C       = 20;    // Cool-down before restart, degC

  // ----------------------------------------------------------------------
  // Register offsets (plain port bus) and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS  = 4'h0; // Live state, read only
  localparam logic [3:0] OFS_IRQ     = 4'h1; // Sticky events, W1C
  localparam logic [3:0] OFS_MASK    = 4'h2; // Event mask
  localparam logic [3:0] OFS_LIMITS  = 4'h3; // Limit figures, read only
  localparam logic [7:0] MASK_RST    = 8'h00;

  // Event bit positions in IRQ and MASK
  localparam int EV_ATTACH  = 0;
  localparam int EV_DETACH  = 1;
  localparam int EV_AUDIO   = 2;
  localparam int EV_DEBUG   = 3;
  localparam int EV_THERMAL = 4;
  localparam int EV_UVLO    = 5;
  localparam int EV_W       = 6;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Termination seen on one configuration line
  typedef enum logic [1:0] {
    TERM_OPEN,
    TERM_SINK,
    TERM_CABLE
  } tcsac_term_t;

  // Advertised current level
  typedef enum logic [1:0] {
    ADV_STD,
    ADV_1A5,
    ADV_3A0
  } tcsac_adv_t;

  // Decoded port condition
  typedef struct packed {
    logic sink;        // Sink seen on exactly one line
    logic flip;        // Sink is on CC2
    logic vconn_cc1;   // Cable power onto CC1
    logic vconn_cc2;   // Cable power onto CC2
    logic audio;       // Cable termination on both lines
    logic debug;       // Sink termination on both lines
  } tcsac_port_t;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tcsac_bus_t;

endpackage

//--- logic/tcsac_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
`default_nettype none
module tcsac_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // ----------------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- logic/tcsac_filter.sv
// Settle filter: output follows input once stable for a set time
`timescale 1ns/100ps
`default_nettype none
module tcsac_filter #(
  parameter int W       = 6,
  parameter int RISE_CY = 16,  // Stable time before a bit sets
  parameter int FALL_CY = 4    // Stable time before a bit clears
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Raw and settled values
  input  wire logic [W-1:0] raw_i,
  output logic      [W-1:0] filt_o
);

  logic [31:0] cnt_q;   // Cycles the candidate has stayed
  logic [W-1:0] cand_q; // Candidate value under watch
  logic        adding;  // Candidate sets a bit that the output has clear
  logic [31:0] need;    // Length for this kind of change

  // Setting a flag waits long, releasing waits short
  assign adding = |(cand_q & ~filt_o);
  assign need   = adding ? 32'(RISE_CY) : 32'(FALL_CY);

  // ----------------------------------------------------------------------
  // Watch the candidate; any change restarts the count
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      cand_q <= '0;
      filt_o <= '0;
    end else if (raw_i != cand_q) begin
      cand_q <= raw_i;
      cnt_q  <= '0;
    end else if (cand_q == filt_o) begin
      cnt_q  <= '0;
    end else if (cnt_q + 32'h1 >= need) begin
      filt_o <= cand_q;
      cnt_q  <= '0;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
    end
  end

endmodule
`default_nettype wire

//--- logic/tcsac_top.sv
// Type-C source attach control: detection, flags, power switch decisions
`timescale 1ns/100ps
`default_nettype none
module tcsac_top
  import tcsac_pkg::*;
#(
  parameter int RISE_CY = tcsac_pkg::DEGR_CYC,
  parameter int FALL_CY = tcsac_pkg::DEGF_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Configuration line comparators (pins, asynchronous)
  input  wire logic       cc1_below_open_i,   // CC1 below unterminated level
  input  wire logic       cc1_below_sink_i,   // CC1 down at cable level
  input  wire logic       cc2_below_open_i,
  input  wire logic       cc2_below_sink_i,
  // Control pins (asynchronous)
  input  wire logic       enable_i,
  input  wire logic       advert_sel_lo_i,
  input  wire logic       advert_sel_hi_i,
  input  wire logic       uvlo_ok_i,          // Supply above turn-on level
  input  wire logic       in_limit_i,         // Bus switch in current limit
  input  wire logic       temp_hot_i,         // Junction above trip point
  input  wire logic       temp_cool_i,        // Junction cooled by margin
  input  wire logic       vconn_overload_i,   // Cable power limiter active
  input  wire logic       heavy_load_i,       // Output above heavy-load level
  // Register port
  input  wire tcsac_pkg::tcsac_bus_t bus_i,
  output logic [7:0]      rdata_o,
  // Power switches
  output logic            bus_power_on_o,     // Charge supply onto bus
  output logic            vconn_cc1_on_o,     // Cable power supply onto CC1
  output logic            vconn_cc2_on_o,
  output logic            vconn_limit_en_o,   // Cable power limiter armed
  output logic [1:0]      advert_level_o,     // tcsac_adv_t code
  output logic            cc_monitor_en_o,
  // Open-drain flags: output low when asserted, enable low drives
  output logic            orientation_flag_n_o,
  output logic            orientation_flag_oe_n_o,
  output logic            sink_attached_n_o,
  output logic            sink_attached_oe_n_o,
  output logic            audio_flag_n_o,
  output logic            audio_flag_oe_n_o,
  output logic            debug_flag_n_o,
  output logic            debug_flag_oe_n_o,
  // Interrupt
  output logic            irq_o
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  logic [12:0] pin_s;   // Synchronised pin levels
  tcsac_sync #(.W(13)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({cc1_below_open_i, cc1_below_sink_i, cc2_below_open_i,
                cc2_below_sink_i, enable_i, advert_sel_lo_i,
                advert_sel_hi_i, uvlo_ok_i, in_limit_i, temp_hot_i,
                temp_cool_i, vconn_overload_i, heavy_load_i}),
    .q_o     (pin_s)
  );

  wire cc1_open_lo = pin_s[12];
  wire cc1_sink_lo = pin_s[11];
  wire cc2_open_lo = pin_s[10];
  wire cc2_sink_lo = pin_s[9];
  wire en_s        = pin_s[8];
  wire sel_lo_s    = pin_s[7];
  wire sel_hi_s    = pin_s[6];
  wire uvlo_ok_s   = pin_s[5];
  wire limit_s     = pin_s[4];
  wire hot_s       = pin_s[3];
  wire cool_s      = pin_s[2];
  wire vc_ovl_s    = pin_s[1];
  wire heavy_s     = pin_s[0];

  // ----------------------------------------------------------------------
  // Termination decode
  // ----------------------------------------------------------------------
  // Voltage below open level but above cable level is a sink termination
  function automatic tcsac_term_t term_of(input logic below_open,
                                          input logic below_sink);
    if (!below_open)
      term_of = TERM_OPEN;
    else if (below_sink)
      term_of = TERM_CABLE;
    else
      term_of = TERM_SINK;
  endfunction

  tcsac_term_t t1;  // CC1 termination
  tcsac_term_t t2;  // CC2 termination
  // Monitor is off while disabled; lines then read as open
  assign t1 = en_s ? term_of(cc1_open_lo, cc1_sink_lo) : TERM_OPEN;
  assign t2 = en_s ? term_of(cc2_open_lo, cc2_sink_lo) : TERM_OPEN;

  // ----------------------------------------------------------------------
  // Raw port condition
  // ----------------------------------------------------------------------
  tcsac_port_t port_q;  // Settled condition
  tcsac_port_t raw;
  wire one_sink = (t1 == TERM_SINK) ^ (t2 == TERM_SINK);
  wire two_sink = (t1 == TERM_SINK) && (t2 == TERM_SINK);
  wire two_cbl  = (t1 == TERM_CABLE) && (t2 == TERM_CABLE);

  // A held accessory masks the sink, so no power reaches an accessory
  assign raw.sink      = one_sink && !raw.audio && !raw.debug;
  assign raw.flip      = one_sink && (t2 == TERM_SINK);
  assign raw.vconn_cc1 = raw.sink && (t1 == TERM_CABLE);
  assign raw.vconn_cc2 = raw.sink && (t2 == TERM_CABLE);
  // Audio held while CC2 keeps its cable termination once settled
  assign raw.audio     = two_cbl ||
                         (port_q.audio && (t2 == TERM_CABLE));
  // Debug held while CC1 keeps its sink termination once settled
  assign raw.debug     = two_sink ||
                         (port_q.debug && (t1 == TERM_SINK));

  // ----------------------------------------------------------------------
  // Debounce of the decoded condition
  // ----------------------------------------------------------------------
  tcsac_filter #(
    .W       (6),
    .RISE_CY (RISE_CY),
    .FALL_CY (FALL_CY)
  ) u_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (raw),
    .filt_o  (port_q)
  );

  // ----------------------------------------------------------------------
  // Thermal cycling: off when hot in limit, back on when cooled
  // ----------------------------------------------------------------------
  logic therm_off_q;
  logic therm_off_d;
  assign therm_off_d = therm_off_q ? !cool_s
                                   : (hot_s && limit_s);

  // ----------------------------------------------------------------------
  // Power and flag decisions
  // ----------------------------------------------------------------------
  // Disable cuts every power switch and flag immediately, without waiting for the filter
  wire live      = en_s;
  wire bus_on_d  = live && port_q.sink && uvlo_ok_s &&
                   !therm_off_q && !therm_off_d;
  wire vc1_d     = live && port_q.vconn_cc1;
  wire vc2_d     = live && port_q.vconn_cc2;
  wire aud_d     = live && port_q.audio;
  wire dbg_d     = live && port_q.debug;
  wire snk_d     = live && port_q.sink;
  wire ori_d     = live && port_q.sink && port_q.flip;

  // Level choice from the select pins
  logic [1:0] adv_d;
  assign adv_d = !sel_lo_s ? 2'(ADV_STD) :
                 (sel_hi_s ? 2'(ADV_3A0) : 2'(ADV_1A5));

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  logic [EV_W-1:0] irq_q;   // Sticky events
  logic [EV_W-1:0] mask_q;  // One enables an event onto irq_o
  logic [EV_W-1:0] ev;      // Event pulses this cycle
  logic            snk_q;
  logic            uvlo_q;

  assign ev[EV_ATTACH]  = snk_d && !snk_q;
  assign ev[EV_DETACH]  = !snk_d && snk_q;
  assign ev[EV_AUDIO]   = aud_d && audio_flag_n_o;
  assign ev[EV_DEBUG]   = dbg_d && debug_flag_n_o;
  assign ev[EV_THERMAL] = therm_off_d && !therm_off_q;
  assign ev[EV_UVLO]    = !uvlo_ok_s && uvlo_q;

  wire wr_irq  = bus_i.wr && (bus_i.addr == OFS_IRQ);
  wire wr_mask = bus_i.wr && (bus_i.addr == OFS_MASK);
  // Set wins over a simultaneous write-one clear
  wire [EV_W-1:0] irq_d = ev |
                          (irq_q & ~(wr_irq ? bus_i.wdata[EV_W-1:0]
                                            : {EV_W{1'b0}}));

  // Live state: power and flag decisions plus monitored limits
  wire [7:0] status_v = {heavy_s, vc_ovl_s, therm_off_q, uvlo_ok_s,
                         bus_power_on_o, ori_d, snk_d, live};
  // Limit figures in units of 250 mA, fixed for every level
  wire [7:0] limits_v = {4'(ILIM_MA / 250), 4'(HEAVY_MA / 250)};

  logic [7:0] rd_v;
  always_comb begin
    case (bus_i.addr)
      OFS_STATUS: rd_v = status_v;
      OFS_IRQ:    rd_v = {2'h0, irq_q};
      OFS_MASK:   rd_v = {2'h0, mask_q};
      OFS_LIMITS: rd_v = limits_v;
      default:    rd_v = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      therm_off_q <= 1'b0;
      irq_q       <= '0;
      mask_q      <= MASK_RST[EV_W-1:0];
      snk_q       <= 1'b0;
      uvlo_q      <= 1'b0;
      rdata_o     <= 8'h00;
    end else begin
      therm_off_q <= therm_off_d;
      irq_q       <= irq_d;
      snk_q       <= snk_d;
      uvlo_q      <= uvlo_ok_s;
      if (wr_mask)
        mask_q <= bus_i.wdata[EV_W-1:0];
      rdata_o     <= bus_i.rd ? rd_v : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers; flags idle released (oe_n high, level high)
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_power_on_o          <= 1'b0;
      vconn_cc1_on_o          <= 1'b0;
      vconn_cc2_on_o          <= 1'b0;
      vconn_limit_en_o        <= 1'b0;
      advert_level_o          <= 2'(ADV_STD);
      cc_monitor_en_o         <= 1'b0;
      orientation_flag_n_o    <= 1'b1;
      orientation_flag_oe_n_o <= 1'b1;
      sink_attached_n_o       <= 1'b1;
      sink_attached_oe_n_o    <= 1'b1;
      audio_flag_n_o          <= 1'b1;
      audio_flag_oe_n_o       <= 1'b1;
      debug_flag_n_o          <= 1'b1;
      debug_flag_oe_n_o       <= 1'b1;
      irq_o                   <= 1'b0;
    end else begin
      bus_power_on_o          <= bus_on_d;
      vconn_cc1_on_o          <= vc1_d;
      vconn_cc2_on_o          <= vc2_d;
      vconn_limit_en_o        <= vc1_d || vc2_d;
      advert_level_o          <= adv_d;
      cc_monitor_en_o         <= live;
      // Open-drain: asserted drives low, otherwise floats
      orientation_flag_n_o    <= !ori_d;
      orientation_flag_oe_n_o <= !ori_d;
      sink_attached_n_o       <= !snk_d;
      sink_attached_oe_n_o    <= !snk_d;
      audio_flag_n_o          <= !aud_d;
      audio_flag_oe_n_o       <= !aud_d;
      debug_flag_n_o          <= !dbg_d;
      debug_flag_oe_n_o       <= !dbg_d;
      irq_o                   <= |(irq_d & mask_q);
    end
  end

  // No D+ or D- port exists on this block by design

endmodule
`default_nettype wire

//--- verification/tcsac_party.sv
// Model of the attached party: sets the line comparator levels
`timescale 1ns/100ps
`default_nettype none
module tcsac_party
  import tcsac_pkg::*;
(
  // Termination placed on each line by the bench
  input  wire tcsac_pkg::tcsac_term_t cc1_term_i,
  input  wire tcsac_pkg::tcsac_term_t cc2_term_i,
  // Comparator levels seen by the port
  output logic                        cc1_below_open_o,
  output logic                        cc1_below_sink_o,
  output logic                        cc2_below_open_o,
  output logic                        cc2_below_sink_o
);
  // -----------------------------------------------------------
  // Termination to voltage
  // -----------------------------------------------------------
  // Any termination pulls below open; cable pulls lower still
  assign cc1_below_open_o = (cc1_term_i != TERM_OPEN);
  assign cc1_below_sink_o = (cc1_term_i == TERM_CABLE);
  assign cc2_below_open_o = (cc2_term_i != TERM_OPEN);
  assign cc2_below_sink_o = (cc2_term_i == TERM_CABLE);
endmodule
`default_nettype wire

//--- verification/tcsac_checker_assertions.sv
// Checker: port-level properties of the attach control
`timescale 1ns/100ps
`default_nettype none
module tcsac_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // Control pins
  input wire logic       enable_i,
  input wire logic       advert_sel_lo_i,
  input wire logic       advert_sel_hi_i,
  input wire logic       uvlo_ok_i,
  input wire logic       in_limit_i,
  input wire logic       temp_hot_i,
  // Power switches and flags
  input wire logic       bus_power_on_o,
  input wire logic       vconn_cc1_on_o,
  input wire logic       vconn_cc2_on_o,
  input wire logic       vconn_limit_en_o,
  input wire logic [1:0] advert_level_o,
  input wire logic       cc_monitor_en_o,
  input wire logic       orientation_flag_n_o,
  input wire logic       orientation_flag_oe_n_o,
  input wire logic       sink_attached_n_o,
  input wire logic       sink_attached_oe_n_o,
  input wire logic       audio_flag_n_o,
  input wire logic       audio_flag_oe_n_o,
  input wire logic       debug_flag_n_o,
  input wire logic       debug_flag_oe_n_o
);
  // -----------------------------------------------------------
  // Properties
  // -----------------------------------------------------------
  // Pins pass two sync flops and a register: four samples cover it
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_flag_open_drain: assert property (
    sink_attached_n_o == sink_attached_oe_n_o &&
    orientation_flag_n_o == orientation_flag_oe_n_o &&
    audio_flag_n_o == audio_flag_oe_n_o &&
    debug_flag_n_o == debug_flag_oe_n_o)
    else $error("flag level and drive enable disagree");
  a_orient_needs_sink: assert property (
    !orientation_flag_n_o |-> !sink_attached_n_o)
    else $error("orientation flag without attached sink");
  a_bus_sink_only: assert property (
    bus_power_on_o |-> !sink_attached_n_o && audio_flag_n_o &&
    debug_flag_n_o)
    else $error("bus power without a single sink");
  a_bus_rise_cause: assert property (
    $rose(bus_power_on_o) |-> $past(uvlo_ok_i, 3) && $past(enable_i, 3))
    else $error("bus power rose while locked out or disabled");
  a_vconn_one_line: assert property (
    (vconn_cc1_on_o || vconn_cc2_on_o) |-> !sink_attached_n_o &&
    !(vconn_cc1_on_o && vconn_cc2_on_o) && audio_flag_n_o)
    else $error("cable power on a wrong line");
  a_vconn_limited: assert property (
    (vconn_cc1_on_o || vconn_cc2_on_o) |-> vconn_limit_en_o)
    else $error("cable power without its limiter");
  a_enable_release: assert property (
    (!enable_i)[*4] |-> !bus_power_on_o && !vconn_cc1_on_o &&
    !vconn_cc2_on_o && !cc_monitor_en_o && sink_attached_n_o &&
    orientation_flag_n_o && audio_flag_n_o && debug_flag_n_o)
    else $error("outputs active while disabled");
  a_thermal_trip: assert property (
    (temp_hot_i && in_limit_i)[*4] |-> !bus_power_on_o)
    else $error("bus power on while hot in limit");
  a_uvlo_hold: assert property (
    (!uvlo_ok_i)[*4] |-> !bus_power_on_o)
    else $error("bus power on under lockout");
  a_advert_std: assert property (
    (!advert_sel_lo_i)[*4] |-> advert_level_o == 2'h0)
    else $error("advert level not standard");
  a_advert_mid: assert property (
    (enable_i && advert_sel_lo_i && !advert_sel_hi_i)[*4]
    |-> advert_level_o == 2'h1)
    else $error("advert level not 1.5 A");
  a_advert_top: assert property (
    (enable_i && advert_sel_lo_i && advert_sel_hi_i)[*4]
    |-> advert_level_o == 2'h2)
    else $error("advert level not 3 A");
endmodule

// Every checker port has the name of the top port that it watches
bind tcsac_top tcsac_checker u_chk (.*);
`default_nettype wire

//--- verification/tb_top.sv
// Bench: attach decode table, protection paths and registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tcsac_pkg::*;
  // -----------------------------------------------------------
  // Signals
  // -----------------------------------------------------------
  typedef struct packed {
    tcsac_term_t c1;       // Termination on CC1
    tcsac_term_t c2;       // Termination on CC2
    logic [6:0]  e;        // Expected power and pulled-up flag levels
  } tcsac_row_t;
  logic        clk_i, rst_n_i, en, sel_lo, sel_hi, uvlo_ok;
  logic        in_limit, hot, cool, vovl, heavy;
  tcsac_term_t cc1_term, cc2_term;
  logic        cc1_open, cc1_sink, cc2_open, cc2_sink;
  tcsac_bus_t  bus;
  logic [7:0]  rdata;
  logic [1:0]  level;
  logic        bus_on, vc1, vc2, vlim, mon_en, irq;
  logic        ori_n, ori_oe, snk_n, snk_oe, aud_n, aud_oe, dbg_n, dbg_oe;
  int          miscompares, checks;
  // Wire levels with the board pull-ups: a released flag reads high
  wire logic [6:0] obs = {bus_on, vc1, vc2, ori_n | ori_oe,
                          snk_n | snk_oe, aud_n | aud_oe, dbg_n | dbg_oe};
  tcsac_row_t rows [10] = '{
    '{TERM_OPEN, TERM_OPEN, 7'h0F}, '{TERM_SINK, TERM_OPEN, 7'h4B},
    '{TERM_OPEN, TERM_SINK, 7'h43}, '{TERM_OPEN, TERM_CABLE, 7'h0F},
    '{TERM_CABLE, TERM_OPEN, 7'h0F}, '{TERM_SINK, TERM_CABLE, 7'h5B},
    '{TERM_CABLE, TERM_SINK, 7'h63}, '{TERM_SINK, TERM_SINK, 7'h0E},
    '{TERM_CABLE, TERM_CABLE, 7'h0D}, '{TERM_OPEN, TERM_OPEN, 7'h0F}};
  logic [7:0]  adv_exp [4] = '{8'h00, 8'h01, 8'h00, 8'h02};

  // -----------------------------------------------------------
  // Design and attached party
  // -----------------------------------------------------------
  tcsac_party u_party (.cc1_term_i(cc1_term), .cc2_term_i(cc2_term),
    .cc1_below_open_o(cc1_open), .cc1_below_sink_o(cc1_sink),
    .cc2_below_open_o(cc2_open), .cc2_below_sink_o(cc2_sink));
  // Short settle counts keep the run brief
  tcsac_top #(.RISE_CY(8), .FALL_CY(4)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .cc1_below_open_i(cc1_open), .cc1_below_sink_i(cc1_sink),
    .cc2_below_open_i(cc2_open), .cc2_below_sink_i(cc2_sink),
    .enable_i(en), .advert_sel_lo_i(sel_lo), .advert_sel_hi_i(sel_hi),
    .uvlo_ok_i(uvlo_ok), .in_limit_i(in_limit), .temp_hot_i(hot),
    .temp_cool_i(cool), .vconn_overload_i(vovl), .heavy_load_i(heavy),
    .bus_i(bus), .rdata_o(rdata), .bus_power_on_o(bus_on),
    .vconn_cc1_on_o(vc1), .vconn_cc2_on_o(vc2), .vconn_limit_en_o(vlim),
    .advert_level_o(level), .cc_monitor_en_o(mon_en),
    .orientation_flag_n_o(ori_n), .orientation_flag_oe_n_o(ori_oe),
    .sink_attached_n_o(snk_n), .sink_attached_oe_n_o(snk_oe),
    .audio_flag_n_o(aud_n), .audio_flag_oe_n_o(aud_oe),
    .debug_flag_n_o(dbg_n), .debug_flag_oe_n_o(dbg_oe), .irq_o(irq));

  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  always #5 clk_i = ~clk_i;
  // Off-edge sampling so output updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Long enough for sync plus the assert filter
  task automatic attach(input tcsac_term_t a, input tcsac_term_t b);
    @(posedge clk_i);
    cc1_term <= a;
    cc2_term <= b;
    settle(30);
  endtask
  task automatic chk_out(input logic [6:0] e, input logic [6:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t outputs %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t level %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    bus <= '0;
    #1;
    chk_reg(e, rdata);
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // -----------------------------------------------------------
  // Sequence
  // -----------------------------------------------------------
  // Watchdog: the sequence needs about seven hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    {clk_i, rst_n_i, sel_lo, sel_hi, in_limit, hot, cool} = '0;
    {vovl, heavy, bus} = '0;
    {en, uvlo_ok} = 2'b11;
    cc1_term = TERM_OPEN;
    cc2_term = TERM_OPEN;
    settle(3);
    chk_out(7'h0F, obs);
    chk_bit(1'b0, irq);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_LIMITS, 8'hD7);
    wr(OFS_LIMITS, 8'h00);
    rd(OFS_LIMITS, 8'hD7);
    rd(OFS_MASK, MASK_RST);
    rd(4'hF, 8'h00);
    // Table walk: each row steps from the previous attachment
    foreach (rows[i]) begin
      attach(rows[i].c1, rows[i].c2);
      chk_out(rows[i].e, obs);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      sel_lo <= i[0];
      sel_hi <= i[1];
      settle(5);
      chk_reg(adv_exp[i], {6'h00, level});
    end
    @(posedge clk_i);
    {sel_lo, sel_hi} <= 2'b00;
    // A short termination pulse must leave every flag alone
    @(posedge clk_i);
    cc1_term <= TERM_SINK;
    settle(4);
    chk_out(7'h0F, obs);
    attach(TERM_OPEN, TERM_OPEN);
    chk_out(7'h0F, obs);
    // Accessory detach is watched on one line only
    attach(TERM_SINK, TERM_SINK);
    attach(TERM_SINK, TERM_OPEN);
    chk_bit(1'b0, dbg_n | dbg_oe);
    attach(TERM_OPEN, TERM_SINK);
    chk_bit(1'b1, dbg_n | dbg_oe);
    attach(TERM_CABLE, TERM_CABLE);
    attach(TERM_OPEN, TERM_CABLE);
    chk_bit(1'b0, aud_n | aud_oe);
    attach(TERM_CABLE, TERM_OPEN);
    chk_bit(1'b1, aud_n | aud_oe);
    // Interrupt: raise masked, unmask, clear
    wr(OFS_IRQ, 8'h3F);
    rd(OFS_IRQ, 8'h00);
    attach(TERM_SINK, TERM_OPEN);
    chk_bit(1'b0, irq);
    rd(OFS_IRQ, 8'h01);
    wr(OFS_MASK, 8'h01);
    settle(2);
    chk_bit(1'b1, irq);
    wr(OFS_IRQ, 8'h01);
    settle(2);
    chk_bit(1'b0, irq);
    @(posedge clk_i);
    {heavy, vovl} <= 2'b11;
    settle(5);
    rd(OFS_STATUS, 8'hDB);
    @(posedge clk_i);
    {heavy, vovl, uvlo_ok} <= 3'b000;
    settle(5);
    chk_bit(1'b0, bus_on);
    @(posedge clk_i);
    uvlo_ok <= 1'b1;
    settle(5);
    chk_bit(1'b1, bus_on);
    // Thermal cycling: trip, hold while warm, restart, trip again
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      {in_limit, hot, cool} <= 3'b110;
      settle(5);
      chk_bit(1'b0, bus_on);
      @(posedge clk_i);
      hot <= 1'b0;
      settle(10);
      chk_bit(1'b0, bus_on);
      @(posedge clk_i);
      {in_limit, cool} <= 2'b01;
      settle(5);
      chk_bit(1'b1, bus_on);
    end
    @(posedge clk_i);
    {hot, cool} <= 2'b10;
    settle(5);
    chk_bit(1'b1, bus_on);
    @(posedge clk_i);
    {hot, en} <= 2'b00;
    settle(6);
    chk_out(7'h0F, obs);
    chk_bit(1'b0, mon_en);
    @(posedge clk_i);
    en <= 1'b1;
    settle(30);
    chk_out(7'h4B, obs);
    complete_run();
  end
endmodule
`default_nettype wire
